// file: verilog/uemr_responder.sv
// Endpoint mode responder of the USB token engine, with an APB register slave.
// Assumes token, ack and receive strobes come from logic on pclk; no synchroniser is needed.
//
// Functional notes
// - Mode 0000: no answer to SETUP, IN or OUT on that endpoint.
// - Mode 0001: accept SETUP, NAK every IN and every intact OUT.
// - Mode 0010: accept SETUP, STALL IN, status check on OUT.
// - Mode 0011: accept SETUP, STALL both IN and OUT.
// - Mode 0110: accept SETUP, zero-length data to IN, STALL OUT.
// - Mode 1111: accept SETUP, send programmed count on IN, status check on OUT.
// - Mode 1000: ignore SETUP and IN, NAK every intact OUT.
// - Mode 1001 stall clear: ACK OUT, then mode becomes 1000 by hardware.
// - Mode 1001 stall set: STALL OUT, ignore SETUP and IN.
// - Mode 1100: ignore SETUP and OUT, NAK every IN.
// - Mode 1101 stall clear: send count on IN; host ACK turns mode to 1100.
// - Mode 1101 stall set: STALL IN, ignore SETUP and OUT.
// - Reserved encodings ignore every token.
// - Mode comes from bits 3:0 of each endpoint's own mode register.
// - Status check ACKs only zero data bytes with toggle 1, else STALL.
// - Programmed transmission sends exactly the 4-bit count of that endpoint.
// - Each endpoint owns an 8-byte buffer for IN source and OUT/SETUP data.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module uemr_responder
   import uemr_pkg::*;
#(
   parameter int unsigned NUM_EP    = UEMR_NUM_EP,
   parameter int unsigned BUF_BYTES = UEMR_BUF_BYTES
) (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic [UEMR_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Token side from the packet decoder
   input  wire logic                   tok_valid,
   input  wire uemr_tok_s              tok,
   input  wire logic                   host_ack,
   input  wire logic [1:0]             host_ack_ep,
   // Received data into the endpoint buffers
   input  wire logic                   rx_wr,
   input  wire logic [1:0]             rx_ep,
   input  wire logic [2:0]             rx_idx,
   input  wire logic [7:0]             rx_data,
   // Transmit data out of the endpoint buffers
   input  wire logic [1:0]             tx_ep,
   input  wire logic [2:0]             tx_idx,
   output logic      [7:0]             tx_data,
   // Handshake decision
   output logic                        resp_valid,
   output uemr_resp_s                  resp
);

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (NUM_EP < 1 || NUM_EP > 4) begin : g_bad_ep
      $error("NUM_EP must be 1 to 4");
   end
   if (BUF_BYTES < 1 || BUF_BYTES > 8) begin : g_bad_buf
      $error("BUF_BYTES must be 1 to 8");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [3:0] mode  [NUM_EP];
   logic       stall [NUM_EP];
   logic [3:0] count [NUM_EP];
   logic       tog   [NUM_EP];
   logic [7:0] buf_q [NUM_EP][BUF_BYTES];

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   function automatic uemr_dec_s decode_addr(input logic [UEMR_ADDR_W-1:0] a);
      uemr_dec_s d;
      logic [7:0] rel;
      d = '{area: UEMR_A_NONE, ep: 2'h0, idx: 3'h0};
      rel = 8'h00;
      if (a[1:0] == 2'h0) begin
         if (a >= UEMR_OFS_MODE && a < UEMR_OFS_MODE + 8'(4 * NUM_EP)) begin
            rel = a - UEMR_OFS_MODE;
            d.area = UEMR_A_MODE;
            d.ep = rel[3:2];
         end else if (a >= UEMR_OFS_COUNT && a < UEMR_OFS_COUNT + 8'(4 * NUM_EP)) begin
            rel = a - UEMR_OFS_COUNT;
            d.area = UEMR_A_COUNT;
            d.ep = rel[3:2];
         end else if (a >= UEMR_OFS_BUF && a < UEMR_OFS_BUF + 8'(UEMR_BUF_SPAN * NUM_EP)) begin
            rel = a - UEMR_OFS_BUF;
            if (32'(rel[4:2]) < BUF_BYTES) begin
               d.area = UEMR_A_BUF;
               d.ep = rel[6:5];
               d.idx = rel[4:2];
            end
         end
      end
      return d;
   endfunction

   // Answer to one token for a given mode; reserved codes fall to NONE
   function automatic uemr_resp_s decide(input logic [3:0] m, input logic st,
                                          input uemr_tok_s t, input logic [3:0] cnt);
      uemr_resp_s r;
      logic       setup, in_t, out_t, chk;
      r = '{code: UEMR_R_NONE, ep: t.ep, len: 4'h0};
      setup = (t.pid == UEMR_PID_SETUP) && t.ok;
      in_t  = (t.pid == UEMR_PID_IN);
      out_t = (t.pid == UEMR_PID_OUT) && t.ok;
      chk   = (t.len == 4'h0) && t.toggle;
      case (m)
         UEMR_M_NAK_IO: begin
            if (setup) r.code = UEMR_R_ACK;
            else if (in_t || out_t) r.code = UEMR_R_NAK;
         end
         UEMR_M_STATUS_OUT: begin
            if (setup) r.code = UEMR_R_ACK;
            else if (in_t) r.code = UEMR_R_STALL;
            else if (out_t) r.code = chk ? UEMR_R_ACK : UEMR_R_STALL;
         end
         UEMR_M_STALL_IO: begin
            if (setup) r.code = UEMR_R_ACK;
            else if (in_t || out_t) r.code = UEMR_R_STALL;
         end
         UEMR_M_STATUS_IN: begin
            if (setup) r.code = UEMR_R_ACK;
            else if (in_t) r.code = UEMR_R_TX;
            else if (out_t) r.code = UEMR_R_STALL;
         end
         UEMR_M_ACK_IN_SO: begin
            if (setup) r.code = UEMR_R_ACK;
            else if (in_t) begin
               r.code = UEMR_R_TX;
               r.len = cnt;
            end else if (out_t) r.code = chk ? UEMR_R_ACK : UEMR_R_STALL;
         end
         UEMR_M_NAK_OUT: begin
            if (out_t) r.code = UEMR_R_NAK;
         end
         UEMR_M_ACK_OUT: begin
            if (out_t) r.code = st ? UEMR_R_STALL : UEMR_R_ACK;
         end
         UEMR_M_NAK_IN: begin
            if (in_t) r.code = UEMR_R_NAK;
         end
         UEMR_M_ACK_IN: begin
            if (in_t) begin
               r.code = st ? UEMR_R_STALL : UEMR_R_TX;
               r.len = st ? 4'h0 : cnt;
            end
         end
         default: r.code = UEMR_R_NONE;
      endcase
      return r;
   endfunction

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   uemr_dec_s  dec;
   logic       apb_acc;
   logic       apb_wr;
   logic       tok_here;
   uemr_resp_s next_resp;

   assign dec      = decode_addr(paddr);
   assign apb_acc  = psel && penable && !pready;
   assign apb_wr   = psel && penable && pready && pwrite && (dec.area != UEMR_A_NONE);
   assign tok_here = tok_valid && (32'(tok.ep) < NUM_EP);
   // mode read at the token's own cycle
   assign next_resp = decide(mode[tok.ep], stall[tok.ep], tok, count[tok.ep]);

   // One wait state: pready rises the cycle after the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_acc;
         pslverr <= apb_acc && (dec.area == UEMR_A_NONE);
         prdata  <= 32'h0000_0000;
         if (apb_acc && !pwrite) begin
            case (dec.area)
               UEMR_A_MODE: begin
                  prdata[UEMR_MODE_LSB +: 4] <= mode[dec.ep];
                  prdata[UEMR_STALL_BIT]     <= stall[dec.ep];
               end
               UEMR_A_COUNT: begin
                  prdata[UEMR_CNT_LSB +: 4] <= count[dec.ep];
                  prdata[UEMR_TOG_BIT]      <= tog[dec.ep];
               end
               UEMR_A_BUF: prdata[7:0] <= buf_q[dec.ep][dec.idx];
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Per-endpoint mode and count registers
   // -----------------------------------------------------------------
   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      logic hw_out_ack, hw_in_ack, hw_stat_ack;
      assign hw_out_ack = tok_here && tok.ep == 2'(e) && mode[e] == UEMR_M_ACK_OUT
                          && next_resp.code == UEMR_R_ACK;
      assign hw_in_ack  = host_ack && host_ack_ep == 2'(e) && mode[e] == UEMR_M_ACK_IN && !stall[e];
      assign hw_stat_ack = tok_here && tok.ep == 2'(e) && tok.pid == UEMR_PID_OUT
                          && next_resp.code == UEMR_R_ACK;

      // Hardware rewrite beats a firmware write in the same cycle so an ACK is never lost
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mode[e]  <= UEMR_MODE_RST;
            stall[e] <= 1'b0;
         end else if (hw_out_ack) begin
            mode[e] <= UEMR_M_NAK_OUT;
         end else if (hw_in_ack) begin
            mode[e] <= UEMR_M_NAK_IN;
         end else if (apb_wr && dec.area == UEMR_A_MODE && dec.ep == 2'(e)) begin
            mode[e]  <= pwdata[UEMR_MODE_LSB +: 4];
            stall[e] <= pwdata[UEMR_STALL_BIT];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            count[e] <= UEMR_CNT_RST;
            tog[e]   <= 1'b0;
         end else begin
            if (apb_wr && dec.area == UEMR_A_COUNT && dec.ep == 2'(e)) begin
               count[e] <= pwdata[UEMR_CNT_LSB +: 4];
               tog[e]   <= pwdata[UEMR_TOG_BIT];
            end
            if (hw_stat_ack) begin
               tog[e] <= tok.toggle;
            end
         end
      end

      // receive strobe wins over firmware on a clash
      for (genvar b = 0; b < BUF_BYTES; b++) begin : g_byte
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               buf_q[e][b] <= UEMR_BUF_RST;
            end else if (rx_wr && rx_ep == 2'(e) && rx_idx == 3'(b)) begin
               buf_q[e][b] <= rx_data;
            end else if (apb_wr && dec.area == UEMR_A_BUF && dec.ep == 2'(e) && dec.idx == 3'(b)) begin
               buf_q[e][b] <= pwdata[7:0];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Transmit data and handshake decision
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data <= UEMR_BUF_RST;
      end else if (32'(tx_ep) < NUM_EP && 32'(tx_idx) < BUF_BYTES) begin
         tx_data <= buf_q[tx_ep][tx_idx];
      end else begin
         tx_data <= UEMR_BUF_RST;
      end
   end

   // Silence is signalled by no resp_valid at all, not a NONE code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_valid <= 1'b0;
         resp       <= '{code: UEMR_R_NONE, ep: 2'h0, len: 4'h0};
      end else begin
         resp_valid <= tok_here && next_resp.code != UEMR_R_NONE;
         if (tok_here) begin
            resp <= next_resp;
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_disable_quiet: assert property (tok_here && mode[tok.ep] == UEMR_M_DISABLE |=> !resp_valid)
      else $error("disabled endpoint answered");
   a_nak_inout: assert property (
         tok_here && mode[tok.ep] == UEMR_M_NAK_IO && tok.pid == UEMR_PID_IN
         |=> resp_valid && resp.code == UEMR_R_NAK)
      else $error("IN under NAK mode not NAKed");
   a_status_check: assert property (
         tok_here && tok.ok && tok.pid == UEMR_PID_OUT
         && (mode[tok.ep] == UEMR_M_STATUS_OUT || mode[tok.ep] == UEMR_M_ACK_IN_SO)
         |=> resp.code == (($past(tok.len) == 4'h0 && $past(tok.toggle)) ? UEMR_R_ACK : UEMR_R_STALL))
      else $error("status check wrong");
   a_stall_inout: assert property (
         tok_here && mode[tok.ep] == UEMR_M_STALL_IO && tok.pid == UEMR_PID_IN
         |=> resp.code == UEMR_R_STALL)
      else $error("STALL mode did not stall IN");
   a_zero_len_in: assert property (
         tok_here && mode[tok.ep] == UEMR_M_STATUS_IN && tok.pid == UEMR_PID_IN
         |=> resp.code == UEMR_R_TX && resp.len == 4'h0)
      else $error("status IN not zero length");
   a_tx_count: assert property (
         tok_here && tok.pid == UEMR_PID_IN && mode[tok.ep] == UEMR_M_ACK_IN_SO
         |=> resp.code == UEMR_R_TX && resp.len == $past(count[tok.ep]))
      else $error("IN length differs from count");
   a_out_rewrite: assert property (
         tok_here && tok.ok && tok.pid == UEMR_PID_OUT
         && mode[tok.ep] == UEMR_M_ACK_OUT && !stall[tok.ep]
         |=> resp.code == UEMR_R_ACK && mode[resp.ep] == UEMR_M_NAK_OUT)
      else $error("ACK OUT did not fall to NAK OUT");
   a_in_rewrite: assert property (
         host_ack && 32'(host_ack_ep) < NUM_EP && mode[host_ack_ep] == UEMR_M_ACK_IN
         && !stall[host_ack_ep] |=> mode[$past(host_ack_ep)] == UEMR_M_NAK_IN)
      else $error("ACK IN did not fall to NAK IN");
   a_data_stall: assert property (
         tok_here && stall[tok.ep] && tok.pid == UEMR_PID_IN
         && mode[tok.ep] == UEMR_M_ACK_IN |=> resp.code == UEMR_R_STALL)
      else $error("stalled IN not stalled");
   a_data_out_stall: assert property (
         tok_here && tok.ok && tok.pid == UEMR_PID_OUT && mode[tok.ep] == UEMR_M_ACK_OUT && stall[tok.ep]
         |=> resp_valid && resp.code == UEMR_R_STALL)
      else $error("stalled OUT not stalled");
   a_nak_out: assert property (
         tok_here && tok.ok && tok.pid == UEMR_PID_OUT && mode[tok.ep] == UEMR_M_NAK_OUT
         |=> resp_valid && resp.code == UEMR_R_NAK)
      else $error("OUT under NAK OUT mode not NAKed");
   a_nak_in: assert property (
         tok_here && tok.pid == UEMR_PID_IN && mode[tok.ep] == UEMR_M_NAK_IN
         |=> resp_valid && resp.code == UEMR_R_NAK)
      else $error("IN under NAK IN mode not NAKed");
   a_reserved_quiet: assert property (
         tok_here && (mode[tok.ep] == 4'h4 || mode[tok.ep] == 4'h5 || mode[tok.ep] == 4'h7
                      || mode[tok.ep] == 4'hA || mode[tok.ep] == 4'hE)
         |=> !resp_valid)
      else $error("reserved mode answered");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held two cycles");

   c_ack_setup: cover property (resp_valid && resp.code == UEMR_R_ACK);
   c_tx_count:  cover property (resp_valid && resp.code == UEMR_R_TX && resp.len != 4'h0);
   c_in_done:   cover property (host_ack ##1 mode[0] == UEMR_M_NAK_IN);
   c_bad_stat:  cover property (resp_valid && resp.code == UEMR_R_STALL);

endmodule
`default_nettype wire

// file: include/uemr_pkg.sv
// Shared constants and carriers of the endpoint mode responder.
// Assumes a single pclk domain and a packet decoder that presents tokens already checked.
package uemr_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int unsigned UEMR_NUM_EP    = 3;
   localparam int unsigned UEMR_BUF_BYTES = 8;
   localparam int unsigned UEMR_ADDR_W    = 8;

   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] UEMR_OFS_MODE  = 8'h00;  // Mode register of ep n at +4n
   localparam logic [7:0] UEMR_OFS_COUNT = 8'h10;  // Count register of ep n at +4n
   localparam logic [7:0] UEMR_OFS_BUF   = 8'h40;  // Buffer of ep n at +20h*n, one byte a word
   localparam logic [7:0] UEMR_BUF_SPAN  = 8'h20;

   // Field positions
   localparam int unsigned UEMR_MODE_LSB  = 0;
   localparam int unsigned UEMR_STALL_BIT = 4;
   localparam int unsigned UEMR_CNT_LSB   = 0;
   localparam int unsigned UEMR_TOG_BIT   = 7;

   // Reset values
   localparam logic [3:0] UEMR_MODE_RST  = 4'h0;
   localparam logic [3:0] UEMR_CNT_RST   = 4'h0;
   localparam logic [7:0] UEMR_BUF_RST   = 8'h00;

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      UEMR_M_DISABLE    = 4'h0,
      UEMR_M_NAK_IO     = 4'h1,
      UEMR_M_STATUS_OUT = 4'h2,
      UEMR_M_STALL_IO   = 4'h3,
      UEMR_M_STATUS_IN  = 4'h6,
      UEMR_M_NAK_OUT    = 4'h8,
      UEMR_M_ACK_OUT    = 4'h9,
      UEMR_M_NAK_IN     = 4'hC,
      UEMR_M_ACK_IN     = 4'hD,
      UEMR_M_ACK_IN_SO  = 4'hF
   } uemr_mode_e;

   typedef enum logic [1:0] {
      UEMR_PID_SETUP = 2'h0,
      UEMR_PID_IN    = 2'h1,
      UEMR_PID_OUT   = 2'h2
   } uemr_pid_e;

   typedef enum logic [2:0] {
      UEMR_R_NONE  = 3'h0,
      UEMR_R_ACK   = 3'h1,
      UEMR_R_NAK   = 3'h2,
      UEMR_R_STALL = 3'h3,
      UEMR_R_TX    = 3'h4
   } uemr_resp_e;

   typedef enum logic [1:0] {
      UEMR_A_NONE  = 2'h0,
      UEMR_A_MODE  = 2'h1,
      UEMR_A_COUNT = 2'h2,
      UEMR_A_BUF   = 2'h3
   } uemr_area_e;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      uemr_pid_e  pid;
      logic [1:0] ep;
      logic [3:0] len;     // Data bytes, CRC excluded
      logic       toggle;  // Data toggle of the OUT/SETUP packet
      logic       ok;      // Data packet arrived intact
   } uemr_tok_s;

   typedef struct packed {
      uemr_resp_e code;
      logic [1:0] ep;
      logic [3:0] len;     // Bytes to transmit when code is TX
   } uemr_resp_s;

   typedef struct packed {
      uemr_area_e area;
      logic [1:0] ep;
      logic [2:0] idx;
   } uemr_dec_s;

endpackage

// file: verif/uemr_host_model.sv
// Host model: issues SETUP, IN and OUT tokens and acknowledges IN data.
// Assumes the responder's pclk; its tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module uemr_host_model
   import uemr_pkg::*;
(
   // Clock
   input  wire logic       pclk,
   // Tokens and host handshake
   output logic            tok_valid,
   output uemr_tok_s       tok,
   output logic            host_ack,
   output logic [1:0]      host_ack_ep,
   // Device answer
   input  wire logic       resp_valid,
   input  wire uemr_resp_s resp
);
   initial begin
      tok_valid = 1'b0;
      tok = '0;
      host_ack = 1'b0;
      host_ack_ep = 2'h0;
   end

   // Silence is a legal answer, so the wait is a fixed window
   task automatic send(input uemr_pid_e p, input logic [1:0] e, input logic [3:0] n,
                       input logic tg, input logic k, output logic hit, output uemr_resp_s r);
      hit = 1'b0;
      r = '0;
      @(posedge pclk);
      tok_valid <= 1'b1;
      tok <= '{pid: p, ep: e, len: n, toggle: tg, ok: k};
      @(posedge pclk);
      tok_valid <= 1'b0;
      tok <= uemr_tok_s'(~tok);  // Stale fields must not pass for a token
      repeat (3) begin
         #1;
         if (resp_valid === 1'b1) begin
            hit = 1'b1;
            r = resp;
         end
         @(posedge pclk);
      end
   endtask

   task automatic ack_in(input logic [1:0] e);
      @(posedge pclk);
      host_ack <= 1'b1;
      host_ack_ep <= e;
      @(posedge pclk);
      host_ack <= 1'b0;
      host_ack_ep <= ~e;
   endtask
endmodule
`default_nettype wire

// file: verif/test_usb_endpoint_mode_responder.sv
// Self-checking bench of the endpoint mode responder.
// Assumes a 40 MHz pclk, APB one-wait-state slave and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_usb_endpoint_mode_responder
   import uemr_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        rx_wr, tok_valid, host_ack, resp_valid;
   logic [7:0]  paddr, rx_data, tx_data;
   logic [31:0] pwdata, prdata;
   logic [1:0]  host_ack_ep, rx_ep, tx_ep;
   logic [2:0]  rx_idx, tx_idx;
   uemr_tok_s   tok;
   uemr_resp_s  resp;
   int          err_count, checks_done;
   // Stall, mode, then SETUP, IN, OUT answer codes
   localparam logic [19:0] MTAB [17] = '{20'h00000, 20'h01122, 20'h02131, 20'h03133, 20'h06143,
      20'h0F141, 20'h05000, 20'h07000, 20'h0A000, 20'h04000, 20'h0E000, 20'h08002, 20'h09001,
      20'h19003, 20'h0C020, 20'h0D040, 20'h1D030};

   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   uemr_responder dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tok_valid(tok_valid), .tok(tok), .host_ack(host_ack), .host_ack_ep(host_ack_ep), .rx_wr(rx_wr),
      .rx_ep(rx_ep), .rx_idx(rx_idx), .rx_data(rx_data), .tx_ep(tx_ep), .tx_idx(tx_idx),
      .tx_data(tx_data), .resp_valid(resp_valid), .resp(resp));
   uemr_host_model host (.pclk(pclk), .tok_valid(tok_valid), .tok(tok), .host_ack(host_ack),
      .host_ack_ep(host_ack_ep), .resp_valid(resp_valid), .resp(resp));

   task automatic tally_and_finish;
      $display("mismatches %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic ee);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         err_count++;
         tally_and_finish();
      end else begin
         if (!w) chk("prdata", e, prdata);
         chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic tok_chk(input uemr_pid_e p, input logic [1:0] e, input logic [3:0] n, input logic tg,
                          input logic k, input logic [2:0] ec, input logic [3:0] el);
      logic hit;
      uemr_resp_s r;
      host.send(p, e, n, tg, k, hit, r);
      chk("resp_valid", {31'h0, ec != 3'h0}, {31'h0, hit});
      if (ec != 3'h0) begin
         chk("resp code", {29'h0, ec}, {29'h0, r.code});
         chk("resp ep", {30'h0, e}, {30'h0, r.ep});
         if (ec == 3'h4) chk("resp len", {28'h0, el}, {28'h0, r.len});
      end
   endtask

   task automatic t_reset;
      for (int n = 0; n < 3; n++) begin
         apb(1'b0, 8'(4 * n), 32'h0, 32'h0, 1'b0);
         apb(1'b0, 8'(8'h10 + 4 * n), 32'h0, 32'h0, 1'b0);
      end
      apb(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
   endtask

   task automatic t_modes;
      logic [1:0] e;
      for (int m = 0; m < 3; m++) apb(1'b1, 8'(8'h10 + 4 * m), 32'h9, 32'h0, 1'b0);
      for (int m = 0; m < 17; m++) begin
         e = MTAB[m][15] ? 2'h1 : 2'h0;
         for (int p = 0; p < 3; p++) begin
            apb(1'b1, 8'(4 * e), {27'h0, MTAB[m][16:12]}, 32'h0, 1'b0);
            tok_chk(uemr_pid_e'(p), e, 4'h0, 1'b1, 1'b1, MTAB[m][10 - 4 * p -: 3],
                    (MTAB[m][15:12] == 4'h6) ? 4'h0 : 4'h9);
         end
      end
   endtask

   task automatic t_status;
      apb(1'b1, 8'h00, 32'h2, 32'h0, 1'b0);
      tok_chk(UEMR_PID_OUT, 2'h0, 4'h1, 1'b1, 1'b1, 3'h3, 4'h0);
      apb(1'b1, 8'h00, 32'hF, 32'h0, 1'b0);
      tok_chk(UEMR_PID_OUT, 2'h0, 4'h0, 1'b0, 1'b1, 3'h3, 4'h0);
      tok_chk(UEMR_PID_OUT, 2'h0, 4'h0, 1'b1, 1'b0, 3'h0, 4'h0);
      tok_chk(UEMR_PID_SETUP, 2'h0, 4'h0, 1'b1, 1'b0, 3'h0, 4'h0);
   endtask

   task automatic t_auto;
      apb(1'b1, 8'h04, 32'h9, 32'h0, 1'b0);
      tok_chk(UEMR_PID_OUT, 2'h1, 4'h3, 1'b0, 1'b1, 3'h1, 4'h0);
      tok_chk(UEMR_PID_OUT, 2'h1, 4'h3, 1'b1, 1'b1, 3'h2, 4'h0);
      apb(1'b0, 8'h04, 32'h0, 32'h8, 1'b0);
      apb(1'b1, 8'h18, 32'h8, 32'h0, 1'b0);
      apb(1'b1, 8'h08, 32'hD, 32'h0, 1'b0);
      tok_chk(UEMR_PID_IN, 2'h2, 4'h0, 1'b0, 1'b1, 3'h4, 4'h8);
      host.ack_in(2'h2);
      tok_chk(UEMR_PID_IN, 2'h2, 4'h0, 1'b0, 1'b1, 3'h2, 4'h0);
      apb(1'b0, 8'h08, 32'h0, 32'hC, 1'b0);
   endtask

   task automatic t_buf;
      @(posedge pclk);
      rx_wr <= 1'b1;
      rx_ep <= 2'h2;
      rx_idx <= 3'h7;
      rx_data <= 8'hA5;
      @(posedge pclk);
      rx_wr <= 1'b0;
      rx_data <= 8'h5A;
      apb(1'b0, 8'h9C, 32'h0, 32'hA5, 1'b0);
      apb(1'b1, 8'h6C, 32'h3C, 32'h0, 1'b0);
      tx_ep <= 2'h1;
      tx_idx <= 3'h3;
      repeat (2) @(posedge pclk);
      chk("tx_data", 32'h3C, {24'h0, tx_data});
   endtask

   // Reset in mid-run must bring back disabled modes and cleared buffers
   task automatic t_midreset;
      apb(1'b1, 8'h08, 32'hD, 32'h0, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b0);
      chk("tx_data", 32'h0, {24'h0, tx_data});
      tok_chk(UEMR_PID_IN, 2'h2, 4'h0, 1'b0, 1'b1, 3'h0, 4'h0);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, rx_wr} = '0;
      {paddr, pwdata, rx_ep, rx_idx, rx_data, tx_ep, tx_idx} = '0;
      err_count = 0;
      checks_done = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_modes();
      t_status();
      t_auto();
      t_buf();
      t_midreset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
